// ### core/nwg_gate.sv
// NVM write-protect gate: AXI4-Lite register file for CPU access to data EEPROM and
// program flash, plus a gated port for an external serial programmer.
// Assumes a memory back end that answers each held mem_req with one mem_ack pulse.
//
// Summary of operation
// - Power-up clears store permit bit.
// - Block CPU data writes while power-up timer runs.
// - Data write needs permit and completed key.
// - Self-program lock refuses internal flash writes.
// - Flash writes also need the key sequence.
// - Software cannot change configuration bits.
// - Code protection blocks external port access.
// - CPU reads and writes data memory whatever the code protection bits.
// - CPU flash reads never blocked by protection.
// - Only full erase restores erased configuration; the gate's reset also reloads it.
// - Unprotected or fully protected: self-writes anywhere.
// - Flash access matrix by protect levels.
// - Partial protection limits reads and writes.
// - Key port has no storage.
// - Key is 55h, AAh, then commit.
// - Commit needs permit set beforehand.
// - Write end clears commit, sets done for data writes only.
`timescale 1ns/1ps
`include "nwg_cfg.svh"
module nwg_gate #(
  parameter int unsigned POWERUP_DELAY_TIMER_CYCLES = `NWG_POWERUP_DELAY_TIMER_MS * `NWG_CLK_KHZ,
  parameter logic [10:0] PROT_BASE_A = `NWG_PROT_BASE_A,
  parameter logic [10:0] PROT_BASE_B = `NWG_PROT_BASE_B
) (
  input  wire logic                   clk,
  input  wire logic                   resetn,
  input  wire logic [`NWG_AXI_AW-1:0] s_axi_awaddr,
  input  wire logic                   s_axi_awvalid,
  output logic                        s_axi_awready,
  input  wire logic [31:0]            s_axi_wdata,
  input  wire logic [3:0]             s_axi_wstrb,
  input  wire logic                   s_axi_wvalid,
  output logic                        s_axi_wready,
  output logic [1:0]                  s_axi_bresp,
  output logic                        s_axi_bvalid,
  input  wire logic                   s_axi_bready,
  input  wire logic [`NWG_AXI_AW-1:0] s_axi_araddr,
  input  wire logic                   s_axi_arvalid,
  output logic                        s_axi_arready,
  output logic [31:0]                 s_axi_rdata,
  output logic [1:0]                  s_axi_rresp,
  output logic                        s_axi_rvalid,
  input  wire logic                   s_axi_rready,
  output logic                        irq,
  output logic                        mem_req,
  output logic                        mem_we,
  output logic                        mem_flash,
  output logic [10:0]                 mem_addr,
  output logic [13:0]                 mem_wdata,
  output logic                        mem_erase,
  input  wire logic [13:0]            mem_rdata,
  input  wire logic                   mem_ack,
  input  wire logic                   prog_req,
  input  wire logic                   prog_we,
  input  wire logic                   prog_flash,
  input  wire logic                   prog_cfg_we,
  input  wire logic                   prog_erase,
  input  wire logic [10:0]            prog_addr,
  input  wire logic [13:0]            prog_wdata,
  output logic                        prog_ack,
  output logic                        prog_denied,
  output logic [13:0]                 prog_rdata
);
  localparam nwg_pkg::nwg_state_s RST_VAL = '{
    fsm:     nwg_pkg::NWG_IDLE,
    cfg:     `NWG_CFG_ERASED,
    default: '0
  };

  nwg_pkg::nwg_state_s r_reg;
  nwg_pkg::nwg_state_s r_next;

  logic       key_armed;
  logic       wr_go;
  logic [9:0] widx;
  logic [1:0] cp;

  assign widx  = r_reg.aw_addr[`NWG_AXI_AW-1:2];
  assign wr_go = r_reg.aw_hold && r_reg.w_hold && !r_reg.bvalid;
  assign cp    = {r_reg.cfg[`NWG_CFG_CP1], r_reg.cfg[`NWG_CFG_CP0]};

  // Only a write to the key port advances the key; every other write resets it.
  nwg_key_seq u_key (
    .clk       (clk),
    .resetn    (resetn),
    .key_wr    (wr_go && r_reg.w_strb0 && (widx == `NWG_IDX_KEY)),
    .key_data  (r_reg.w_data),
    .seq_break (wr_go && (widx != `NWG_IDX_KEY)),
    .armed     (key_armed)
  );

  function automatic logic reg_mapped(input logic [9:0] idx);
    case (idx)
      `NWG_IDX_INT_CTRL, `NWG_IDX_PFLAGS2, `NWG_IDX_PENABLE2, `NWG_IDX_DATA_LO,
      `NWG_IDX_ADDR_LO, `NWG_IDX_DATA_HI, `NWG_IDX_ADDR_HI, `NWG_IDX_CTRL,
      `NWG_IDX_KEY, `NWG_IDX_CFG: reg_mapped = 1'b1;
      default: reg_mapped = 1'b0;
    endcase
  endfunction

  // Protected area for a protect level; 0,0 covers all and 1,1 none.
  function automatic logic in_prot(input logic [1:0] lvl, input logic [10:0] addr);
    case (lvl)
      2'b00:   in_prot = 1'b1;
      2'b01:   in_prot = (addr >= PROT_BASE_A);
      2'b10:   in_prot = (addr >= PROT_BASE_B);
      default: in_prot = 1'b0;
    endcase
  endfunction

  always_comb begin
    logic [9:0]  ridx;
    logic [10:0] fl_addr;
    logic        fl_self_ok;
    logic        cmt_ok;
    logic        ext_ok;
    ridx       = s_axi_araddr[`NWG_AXI_AW-1:2];
    fl_addr    = {r_reg.addr_hi, r_reg.addr_lo};
    // Full protection and no protection both allow self writes everywhere.
    fl_self_ok = r_reg.cfg[`NWG_CFG_WRT] && ((cp == 2'b00) || (cp == 2'b11) ||
                 !in_prot(cp, fl_addr));
    cmt_ok     = 1'b0;
    ext_ok     = 1'b0;
    r_next     = r_reg;
    r_next.prog_ack    = 1'b0;
    r_next.prog_denied = 1'b0;
    r_next.mem_erase   = 1'b0;

    if (!r_reg.powerup_delay_timer_done) begin
      r_next.powerup_delay_timer_cnt = r_reg.powerup_delay_timer_cnt + `NWG_POWERUP_DELAY_TIMER_W'(1);
      if (r_reg.powerup_delay_timer_cnt == `NWG_POWERUP_DELAY_TIMER_W'(POWERUP_DELAY_TIMER_CYCLES - 1)) r_next.powerup_delay_timer_done = 1'b1;
    end

    // Address and data channels are taken in either order and held until both are in.
    if (s_axi_awvalid && s_axi_awready) begin
      r_next.aw_hold = 1'b1;
      r_next.aw_addr = s_axi_awaddr;
    end
    if (s_axi_wvalid && s_axi_wready) begin
      r_next.w_hold  = 1'b1;
      r_next.w_data  = s_axi_wdata[7:0];
      r_next.w_strb0 = s_axi_wstrb[0];
    end
    if (r_reg.bvalid && s_axi_bready) r_next.bvalid = 1'b0;

    if (wr_go) begin
      r_next.aw_hold = 1'b0;
      r_next.w_hold  = 1'b0;
      r_next.bvalid  = 1'b1;
      r_next.bresp   = reg_mapped(widx) ? `NWG_RESP_OKAY : `NWG_RESP_SLVERR;
      if (r_reg.w_strb0) begin
        case (widx)
          `NWG_IDX_INT_CTRL: r_next.int_ctrl = r_reg.w_data;
          // Reserved bits are never stored, so they read back zero whatever is written.
          `NWG_IDX_PFLAGS2:  r_next.flags2 = r_reg.flags2 & ~(r_reg.w_data & `NWG_PERIPH_MASK);
          `NWG_IDX_PENABLE2: r_next.enables2 = r_reg.w_data & `NWG_PERIPH_MASK;
          `NWG_IDX_DATA_LO:  r_next.data_lo = r_reg.w_data;
          `NWG_IDX_ADDR_LO:  r_next.addr_lo = r_reg.w_data;
          `NWG_IDX_DATA_HI:  r_next.data_hi = r_reg.w_data[5:0];
          `NWG_IDX_ADDR_HI:  r_next.addr_hi = r_reg.w_data[2:0];
          `NWG_IDX_CTRL: begin
            r_next.flash_sel = r_reg.w_data[`NWG_CTRL_FLASH_SEL];
            r_next.permit    = r_reg.w_data[`NWG_CTRL_PERMIT];
            if (!r_reg.w_data[`NWG_CTRL_ABORT]) r_next.abort = 1'b0;
            // Read and commit bits are set-only; one operation is pending at a time.
            if (r_reg.w_data[`NWG_CTRL_READ] && !r_reg.commit && !r_reg.read_go) begin
              r_next.read_go  = 1'b1;
              r_next.op_flash = r_reg.w_data[`NWG_CTRL_FLASH_SEL];
            end else if (r_reg.w_data[`NWG_CTRL_COMMIT] && !r_reg.commit &&
                         !r_reg.read_go) begin
              // Permit is the value held before this write, so setting both at once fails.
              if (r_reg.w_data[`NWG_CTRL_FLASH_SEL]) begin
                cmt_ok = r_reg.permit && key_armed && fl_self_ok;
              end else begin
                cmt_ok = r_reg.permit && key_armed && r_reg.powerup_delay_timer_done;
              end
              if (cmt_ok) begin
                r_next.commit   = 1'b1;
                r_next.op_flash = r_reg.w_data[`NWG_CTRL_FLASH_SEL];
              end else begin
                r_next.abort = 1'b1;
              end
            end
          end
          // The key port and the configuration word keep nothing from a bus write.
          `NWG_IDX_KEY: ;
          `NWG_IDX_CFG: ;
          default: ;
        endcase
      end
    end

    if (r_reg.rvalid && s_axi_rready) r_next.rvalid = 1'b0;
    if (s_axi_arvalid && s_axi_arready) begin
      r_next.rvalid = 1'b1;
      r_next.rresp  = reg_mapped(ridx) ? `NWG_RESP_OKAY : `NWG_RESP_SLVERR;
      case (ridx)
        `NWG_IDX_INT_CTRL: r_next.rdata = r_reg.int_ctrl;
        `NWG_IDX_PFLAGS2:  r_next.rdata = r_reg.flags2;
        `NWG_IDX_PENABLE2: r_next.rdata = r_reg.enables2;
        `NWG_IDX_DATA_LO:  r_next.rdata = r_reg.data_lo;
        `NWG_IDX_ADDR_LO:  r_next.rdata = r_reg.addr_lo;
        `NWG_IDX_DATA_HI:  r_next.rdata = {2'h0, r_reg.data_hi};
        `NWG_IDX_ADDR_HI:  r_next.rdata = {5'h00, r_reg.addr_hi};
        `NWG_IDX_CTRL:     r_next.rdata = {r_reg.flash_sel, 3'h0, r_reg.abort, r_reg.permit,
                                           r_reg.commit, r_reg.read_go};
        `NWG_IDX_CFG:      r_next.rdata = {4'h0, r_reg.cfg};
        default:           r_next.rdata = 8'h00;
      endcase
    end

    case (r_reg.fsm)
      nwg_pkg::NWG_IDLE: begin
        // CPU operations take precedence over the external programmer.
        if (r_reg.commit || r_reg.read_go) begin
          r_next.fsm       = nwg_pkg::NWG_BUSY;
          r_next.op_cpu    = 1'b1;
          r_next.mem_req   = 1'b1;
          r_next.mem_we    = r_reg.commit;
          r_next.mem_flash = r_reg.op_flash;
          r_next.mem_addr  = r_reg.op_flash ? fl_addr : {3'h0, r_reg.addr_lo};
          r_next.mem_wdata = {r_reg.data_hi, r_reg.data_lo};
        end else if (prog_req && !r_reg.prog_ack) begin
          if (prog_erase) begin
            r_next.cfg       = `NWG_CFG_ERASED;
            r_next.mem_erase = 1'b1;
            r_next.prog_ack  = 1'b1;
          end else if (prog_cfg_we) begin
            // Programming can only clear bits; a 1 comes back only by full erase or by reset.
            r_next.cfg      = r_reg.cfg & prog_wdata[3:0];
            r_next.prog_ack = 1'b1;
          end else begin
            if (!prog_flash) begin
              ext_ok = r_reg.cfg[`NWG_CFG_CPD];
            end else if (prog_we) begin
              ext_ok = (cp == 2'b11);
            end else begin
              ext_ok = !in_prot(cp, prog_addr);
            end
            if (ext_ok) begin
              r_next.fsm       = nwg_pkg::NWG_BUSY;
              r_next.op_cpu    = 1'b0;
              r_next.mem_req   = 1'b1;
              r_next.mem_we    = prog_we;
              r_next.mem_flash = prog_flash;
              r_next.mem_addr  = prog_addr;
              r_next.mem_wdata = prog_wdata;
            end else begin
              r_next.prog_ack    = 1'b1;
              r_next.prog_denied = 1'b1;
            end
          end
        end
      end
      nwg_pkg::NWG_BUSY: begin
        if (mem_ack) begin
          r_next.fsm     = nwg_pkg::NWG_IDLE;
          r_next.mem_req = 1'b0;
          r_next.mem_we  = 1'b0;
          if (!r_reg.op_cpu) begin
            r_next.prog_ack   = 1'b1;
            r_next.prog_rdata = mem_rdata;
          end else if (r_reg.mem_we) begin
            r_next.commit = 1'b0;
            // Set after the clear above, so a completion racing a clear is kept.
            if (!r_reg.mem_flash) r_next.flags2[`NWG_DONE_BIT] = 1'b1;
          end else begin
            r_next.read_go = 1'b0;
            r_next.data_lo = mem_rdata[7:0];
            if (r_reg.mem_flash) r_next.data_hi = mem_rdata[13:8];
          end
        end
      end
      default: r_next.fsm = nwg_pkg::NWG_IDLE;
    endcase
  end

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      r_reg <= RST_VAL;
    end else begin
      r_reg <= r_next;
    end
  end

  assign s_axi_awready = !r_reg.aw_hold && !r_reg.bvalid;
  assign s_axi_wready  = !r_reg.w_hold && !r_reg.bvalid;
  assign s_axi_bvalid  = r_reg.bvalid;
  assign s_axi_bresp   = r_reg.bresp;
  assign s_axi_arready = !r_reg.rvalid;
  assign s_axi_rvalid  = r_reg.rvalid;
  assign s_axi_rresp   = r_reg.rresp;
  assign s_axi_rdata   = {24'h000000, r_reg.rdata};
  assign irq           = |(r_reg.flags2 & r_reg.enables2);
  assign mem_req       = r_reg.mem_req;
  assign mem_we        = r_reg.mem_we;
  assign mem_flash     = r_reg.mem_flash;
  assign mem_addr      = r_reg.mem_addr;
  assign mem_wdata     = r_reg.mem_wdata;
  assign mem_erase     = r_reg.mem_erase;
  assign prog_ack      = r_reg.prog_ack;
  assign prog_denied   = r_reg.prog_denied;
  assign prog_rdata    = r_reg.prog_rdata;
endmodule // nwg_gate

// ### core/nwg_cfg.svh
// Offsets, field positions, reset values and timing counts of the NVM write-protect gate.
// Assumes inclusion by bare name; every register sits at byte address index * 4.
`ifndef NWG_CFG_SVH
`define NWG_CFG_SVH

// Register indices; the byte address on the bus is the index times four.
`define NWG_IDX_INT_CTRL    10'h00B
`define NWG_IDX_PFLAGS2     10'h00D
`define NWG_IDX_PENABLE2    10'h08D
`define NWG_IDX_DATA_LO     10'h10C
`define NWG_IDX_ADDR_LO     10'h10D
`define NWG_IDX_DATA_HI     10'h10E
`define NWG_IDX_ADDR_HI     10'h10F
`define NWG_IDX_CTRL        10'h18C
`define NWG_IDX_KEY         10'h18D
`define NWG_IDX_CFG         10'h190

// Control register fields.
`define NWG_CTRL_FLASH_SEL  7
`define NWG_CTRL_ABORT      3
`define NWG_CTRL_PERMIT     2
`define NWG_CTRL_COMMIT     1
`define NWG_CTRL_READ       0

// Peripheral flag and enable fields.
`define NWG_DONE_BIT        4
`define NWG_PERIPH_MASK     8'h10

// Configuration word fields; a 0 means programmed (active protection or lock).
`define NWG_CFG_WRT         0
`define NWG_CFG_CP0         1
`define NWG_CFG_CP1         2
`define NWG_CFG_CPD         3
`define NWG_CFG_ERASED      4'hF

// Unlock key values.
`define NWG_KEY_FIRST       8'h55
`define NWG_KEY_SECOND      8'hAA

// Power-up delay timer.
`define NWG_POWERUP_DELAY_TIMER_MS         72
`define NWG_CLK_KHZ         125000
`define NWG_POWERUP_DELAY_TIMER_W          24

// First protected program address under each partial protection level.
`define NWG_PROT_BASE_A     11'h400
`define NWG_PROT_BASE_B     11'h600

// AXI responses and widths.
`define NWG_AXI_AW          12
`define NWG_RESP_OKAY       2'h0
`define NWG_RESP_SLVERR     2'h2

`endif

// ### core/nwg_pkg.sv
// Types shared by the NVM write-protect gate modules.
// Assumes nwg_cfg.svh is on the include path.
package nwg_pkg;
  `include "nwg_cfg.svh"

  typedef enum logic [1:0] {
    NWG_IDLE = 2'b01,
    NWG_BUSY = 2'b10
  } nwg_fsm_e;

  typedef enum logic [2:0] {
    NWG_KEY_NONE  = 3'b001,
    NWG_KEY_HALF  = 3'b010,
    NWG_KEY_ARMED = 3'b100
  } nwg_key_e;

  typedef struct packed {
    nwg_key_e st;
  } nwg_key_s;

  typedef struct packed {
    nwg_fsm_e                fsm;
    logic                    op_cpu;
    logic                    op_flash;
    logic [`NWG_POWERUP_DELAY_TIMER_W-1:0]  powerup_delay_timer_cnt;
    logic                    powerup_delay_timer_done;
    logic [7:0]              int_ctrl;
    logic [7:0]              flags2;
    logic [7:0]              enables2;
    logic [7:0]              data_lo;
    logic [7:0]              addr_lo;
    logic [5:0]              data_hi;
    logic [2:0]              addr_hi;
    logic                    flash_sel;
    logic                    abort;
    logic                    permit;
    logic                    commit;
    logic                    read_go;
    logic [3:0]              cfg;
    logic                    aw_hold;
    logic [`NWG_AXI_AW-1:0]  aw_addr;
    logic                    w_hold;
    logic [7:0]              w_data;
    logic                    w_strb0;
    logic                    bvalid;
    logic [1:0]              bresp;
    logic                    rvalid;
    logic [7:0]              rdata;
    logic [1:0]              rresp;
    logic                    mem_req;
    logic                    mem_we;
    logic                    mem_flash;
    logic [10:0]             mem_addr;
    logic [13:0]             mem_wdata;
    logic                    mem_erase;
    logic                    prog_ack;
    logic                    prog_denied;
    logic [13:0]             prog_rdata;
  } nwg_state_s;
endpackage

// ### core/nwg_key_seq.sv
// Unlock key sequencer: tracks the two-value key written to the key port.
// Assumes one write strobe per bus write; any other register write breaks the sequence.
`timescale 1ns/1ps
module nwg_key_seq (
  input  wire logic       clk,
  input  wire logic       resetn,
  input  wire logic       key_wr,
  input  wire logic [7:0] key_data,
  input  wire logic       seq_break,
  output logic            armed
);
  nwg_pkg::nwg_key_s r_reg;
  nwg_pkg::nwg_key_s r_next;

  // The key port holds no value; only the sequence position is kept.
  always_comb begin
    r_next = r_reg;
    if (seq_break) begin
      r_next.st = nwg_pkg::NWG_KEY_NONE;
    end else if (key_wr) begin
      case (r_reg.st)
        nwg_pkg::NWG_KEY_NONE: begin
          if (key_data == `NWG_KEY_FIRST) r_next.st = nwg_pkg::NWG_KEY_HALF;
        end
        nwg_pkg::NWG_KEY_HALF: begin
          if (key_data == `NWG_KEY_SECOND) begin
            r_next.st = nwg_pkg::NWG_KEY_ARMED;
          end else if (key_data == `NWG_KEY_FIRST) begin
            r_next.st = nwg_pkg::NWG_KEY_HALF;
          end else begin
            r_next.st = nwg_pkg::NWG_KEY_NONE;
          end
        end
        default: begin
          if (key_data == `NWG_KEY_FIRST) begin
            r_next.st = nwg_pkg::NWG_KEY_HALF;
          end else begin
            r_next.st = nwg_pkg::NWG_KEY_NONE;
          end
        end
      endcase
    end
  end

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      r_reg <= '{st: nwg_pkg::NWG_KEY_NONE};
    end else begin
      r_reg <= r_next;
    end
  end

  assign armed = (r_reg.st == nwg_pkg::NWG_KEY_ARMED);
endmodule // nwg_key_seq

// ### tb/nwg_props.sv
// Checker for the NVM write-protect gate, watching the gate's own ports only.
// Assumes it is bound into every nwg_gate instance and shares its reset.
`timescale 1ns/1ps
module nwg_props #(parameter int unsigned POWERUP_DELAY_TIMER_CYCLES = 20) (
  input wire logic        clk, resetn, s_axi_awvalid, s_axi_awready, s_axi_wvalid,
  input wire logic        s_axi_wready, s_axi_bvalid, s_axi_arvalid, s_axi_arready,
  input wire logic        s_axi_rvalid, s_axi_rready, mem_req, mem_we, mem_flash,
  input wire logic        mem_ack, mem_erase, prog_ack, prog_denied,
  input wire logic [11:0] s_axi_araddr,
  input wire logic [31:0] s_axi_rdata,
  input wire logic [10:0] mem_addr
);
  logic [31:0] up_cnt;
  always_ff @(posedge clk or negedge resetn)
    if (!resetn) up_cnt <= 32'h0;
    else if (up_cnt < POWERUP_DELAY_TIMER_CYCLES) up_cnt <= up_cnt + 32'h1;
  default clocking @(posedge clk); endclocking
  default disable iff (!resetn);
  a_early_block: assert property (
    up_cnt < POWERUP_DELAY_TIMER_CYCLES |-> !(mem_req && mem_we && !mem_flash)) else $error("early data write");
  a_req_steady: assert property (mem_req && !mem_ack |=> mem_req && $stable(mem_addr)
    && $stable(mem_we) && $stable(mem_flash)) else $error("memory request not held");
  a_deny_acked: assert property (prog_denied |-> prog_ack)
    else $error("refusal without acknowledge");
  a_ack_pulse: assert property (prog_ack |=> !prog_ack) else $error("acknowledge too long");
  a_erase_pulse: assert property (mem_erase |=> !mem_erase)
    else $error("erase pulse too long");
  a_key_reads_zero: assert property (
    s_axi_arvalid && s_axi_arready && s_axi_araddr == 12'h634
    |-> ##[1:2] (s_axi_rvalid && s_axi_rdata == 32'h0)) else $error("key port kept a value");
  a_write_answer: assert property (s_axi_awvalid && s_axi_awready && s_axi_wvalid
    && s_axi_wready |-> ##[1:2] s_axi_bvalid) else $error("write response missing");
  a_read_answer: assert property (s_axi_arvalid && s_axi_arready |-> ##[1:2] s_axi_rvalid)
    else $error("read response missing");
  a_read_hold: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid
    && $stable(s_axi_rdata)) else $error("read data dropped early");
  c_flash_write: cover property (mem_req && mem_we && mem_flash);
  c_prog_refused: cover property (prog_denied);
  c_erase: cover property (mem_erase);
endmodule // nwg_props
bind nwg_gate nwg_props #(.POWERUP_DELAY_TIMER_CYCLES(POWERUP_DELAY_TIMER_CYCLES)) nwg_props_inst (.*);

// ### tb/nwg_mem_model.sv
// Memory back end: answers each held request with one acknowledge pulse.
// Assumes one request at a time; slow adds three wait cycles before the answer.
`timescale 1ns/1ps
module nwg_mem_model (
  input  wire logic        clk, resetn, mem_req, mem_we, mem_flash, mem_erase, slow,
  input  wire logic [10:0] mem_addr,
  input  wire logic [13:0] mem_wdata,
  output logic      [13:0] mem_rdata,
  output logic             mem_ack
);
  logic [13:0] cells [0:4095];
  int          wait_n;
  initial for (int i = 0; i < 4096; i++) cells[i] = 14'h3FFF;
  always @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      mem_ack <= 1'b0;
      mem_rdata <= 14'h0;
      wait_n <= 0;
    end else begin
      mem_ack <= 1'b0;
      // Outside an answer the read bus toggles, so a stale sample never matches.
      mem_rdata <= ~mem_rdata;
      if (mem_erase) for (int i = 0; i < 4096; i++) cells[i] <= 14'h3FFF;
      else if (mem_req && !mem_ack && wait_n < (slow ? 3 : 0)) wait_n <= wait_n + 1;
      else if (mem_req && !mem_ack) begin
        wait_n <= 0;
        mem_ack <= 1'b1;
        mem_rdata <= cells[{mem_flash, mem_addr}];
        if (mem_we) cells[{mem_flash, mem_addr}] <= mem_wdata;
      end
    end
  end
endmodule // nwg_mem_model

// ### tb/tb.sv
// Bench for the NVM gate: AXI master tasks, programmer driver, reference memory.
// Assumes nwg_mem_model on the memory port; power-up delay shortened to PW cycles.
`timescale 1ns/1ps
`include "nwg_cfg.svh"
module tb;
  localparam int PW = 100;
  localparam logic [9:0] CT = `NWG_IDX_CTRL;
  localparam logic [9:0] CF = `NWG_IDX_CFG;
  logic        clk, resetn, s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready;
  logic        s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready, s_axi_rvalid;
  logic        s_axi_rready, irq, mem_req, mem_we, mem_flash, mem_erase, mem_ack, slow;
  logic        prog_req, prog_we, prog_flash, prog_cfg_we, prog_erase, prog_ack, prog_denied;
  logic [11:0] s_axi_awaddr, s_axi_araddr;
  logic [31:0] s_axi_wdata, s_axi_rdata, v;
  logic [3:0]  s_axi_wstrb;
  logic [1:0]  s_axi_bresp, s_axi_rresp, rs;
  logic [10:0] mem_addr, prog_addr;
  logic [13:0] mem_wdata, mem_rdata, prog_wdata, prog_rdata;
  int          fails, checked, cyc, seed;
  int          ref_m[int];
  nwg_gate #(.POWERUP_DELAY_TIMER_CYCLES(PW)) nwg_gate_inst (.*);
  nwg_mem_model nwg_mem_model_inst (.*);
  initial begin
    clk = 1'b0;
    forever #4 clk = ~clk;
  end
  always @(posedge clk) begin
    cyc++;
    if (cyc == 30000) begin
      fails++;
      end_sim();
    end
  end
  function automatic logic [31:0] em(int k);
    return ref_m.exists(k) ? ref_m[k] : 32'h3FFF;
  endfunction
  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    checked++;
    if (g !== e) begin
      fails++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, g, e);
    end
  endtask
  task automatic wr(input logic [9:0] i, input logic [7:0] d);
    logic a, w;
    @(posedge clk);
    s_axi_awaddr <= {i, 2'b00};
    s_axi_wdata <= {24'h0, d};
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    do begin
      @(negedge clk);
      a = s_axi_awready;
      w = s_axi_wready;
      @(posedge clk);
      if (a) s_axi_awvalid <= 1'b0;
      if (w) s_axi_wvalid <= 1'b0;
    end while (s_axi_awvalid || s_axi_wvalid);
    do @(negedge clk); while (!s_axi_bvalid);
    rs = s_axi_bresp;
    @(posedge clk);
    s_axi_bready <= 1'b0;
  endtask
  task automatic rd(input logic [9:0] i);
    @(posedge clk);
    s_axi_araddr <= {i, 2'b00};
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    do @(negedge clk); while (!s_axi_arready);
    @(posedge clk);
    s_axi_arvalid <= 1'b0;
    do @(negedge clk); while (!s_axi_rvalid);
    v = s_axi_rdata;
    rs = s_axi_rresp;
    @(posedge clk);
    s_axi_rready <= 1'b0;
  endtask
  task automatic rdc(input logic [9:0] i, input logic [31:0] e);
    rd(i);
    chk(v, e);
  endtask
  task automatic fetch(input logic fl, input logic [10:0] a);
    logic [31:0] e;
    e = em({fl, a});
    wr(`NWG_IDX_ADDR_LO, a[7:0]);
    wr(`NWG_IDX_ADDR_HI, {5'h0, a[10:8]});
    wr(CT, {fl, 7'h01});
    do rd(CT); while (v[0] === 1'b1);
    rdc(`NWG_IDX_DATA_LO, e & 32'hFF);
    if (fl) rdc(`NWG_IDX_DATA_HI, e >> 8);
  endtask
  // Full store attempt; pre writes store_permit first, cv is the commit write.
  task automatic op(input logic fl, input logic [10:0] a, input logic [7:0] k,
                    input logic pre, input logic [6:0] cv, input logic ok);
    logic [13:0] d;
    d = 14'($random(seed));
    slow <= 1'($random(seed));
    wr(`NWG_IDX_ADDR_LO, a[7:0]);
    wr(`NWG_IDX_ADDR_HI, {5'h0, a[10:8]});
    wr(`NWG_IDX_DATA_LO, d[7:0]);
    wr(`NWG_IDX_DATA_HI, {2'h0, d[13:8]});
    if (pre) wr(CT, {fl, 7'h04});
    wr(`NWG_IDX_KEY, k);
    wr(`NWG_IDX_KEY, ~k);
    wr(CT, {fl, cv});
    do rd(CT); while (v[1] === 1'b1);
    chk(v, {24'h0, fl, cv & 7'h04 | (ok ? 7'h00 : 7'h08)});
    if (ok) ref_m[{fl, a}] = fl ? d : {6'h0, d[7:0]};
    wr(CT, {fl, 7'h04});
    fetch(fl, a);
  endtask
  // Programmer access; m is {write, flash, config write, erase}.
  task automatic pg(input logic [3:0] m, input logic [10:0] a, input logic [13:0] d,
                    input logic den);
    @(posedge clk);
    {prog_we, prog_flash, prog_cfg_we, prog_erase} <= m;
    prog_addr <= a;
    prog_wdata <= d;
    prog_req <= 1'b1;
    do @(negedge clk); while (!prog_ack);
    chk({31'h0, prog_denied}, {31'h0, den});
    v = {18'h0, prog_rdata};
    @(posedge clk);
    prog_req <= 1'b0;
  endtask
  task automatic irq_is(input logic e);
    @(negedge clk);
    chk({31'h0, irq}, {31'h0, e});
  endtask
  task automatic end_sim();
    $display("checked=%0d fails=%0d", checked, fails);
    if (fails == 0 && checked > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask
  initial begin
    {seed, fails, checked, cyc} = {32'd89, 96'h0};
    {resetn, s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = '0;
    {prog_req, prog_we, prog_flash, prog_cfg_we, prog_erase, slow} = '0;
    {s_axi_awaddr, s_axi_araddr, s_axi_wdata, prog_addr, prog_wdata} = '0;
    s_axi_wstrb = 4'hF;
    repeat (12) @(posedge clk);
    resetn <= 1'b1;
    rdc(CT, 32'h0);
    op(0, 11'h05, 8'h55, 1, 7'h06, 0);
    repeat (PW) @(posedge clk);
    rdc(CF, 32'hF);
    rdc(`NWG_IDX_KEY, 32'h0);
    rd(10'h3FF);
    chk({30'h0, rs}, {30'h0, `NWG_RESP_SLVERR});
    wr(`NWG_IDX_INT_CTRL, 8'hA5);
    s_axi_wstrb <= 4'h0;
    wr(`NWG_IDX_INT_CTRL, 8'h3C);
    s_axi_wstrb <= 4'hF;
    rdc(`NWG_IDX_INT_CTRL, 32'hA5);
    wr(10'h3FF, 8'h00);
    chk({30'h0, rs}, {30'h0, `NWG_RESP_SLVERR});
    $display("test reset done");
    op(0, 11'h0A, 8'h55, 1, 7'h06, 1);
    rdc(`NWG_IDX_PFLAGS2, 32'h10);
    irq_is(1'b0);
    wr(`NWG_IDX_PENABLE2, 8'h10);
    irq_is(1'b1);
    wr(`NWG_IDX_PFLAGS2, 8'h10);
    rdc(`NWG_IDX_PFLAGS2, 32'h0);
    irq_is(1'b0);
    op(0, 11'h0A, 8'h55, 0, 7'h06, 0);
    op(0, 11'h0A, 8'h55, 0, 7'h02, 0);
    op(0, 11'h0A, 8'hAA, 1, 7'h06, 0);
    $display("test data store done");
    op(1, 11'h4F3, 8'h55, 1, 7'h06, 1);
    op(1, 11'h4F3, 8'hAA, 1, 7'h06, 0);
    pg(4'h0, 11'h0A, 14'h0, 0);
    chk(v & 32'hFF, em(32'h00A) & 32'hFF);
    pg(4'hC, 11'h123, 14'h2A5C, 0);
    ref_m[32'h923] = 32'h2A5C;
    fetch(1, 11'h123);
    pg(4'h2, 11'h0, 14'h0006, 0);
    wr(CF, 8'h0F);
    rdc(CF, 32'h6);
    op(1, 11'h123, 8'h55, 1, 7'h06, 0);
    $display("test flash lock done");
    pg(4'h1, 11'h0, 14'h0, 0);
    ref_m.delete();
    rdc(CF, 32'hF);
    pg(4'h2, 11'h0, 14'h000B, 0);
    pg(4'h4, 11'h100, 14'h0, 0);
    chk(v, em(32'h900));
    pg(4'h4, 11'h500, 14'h0, 1);
    pg(4'hC, 11'h100, 14'h1, 1);
    op(1, 11'h500, 8'h55, 1, 7'h06, 0);
    op(1, 11'h100, 8'h55, 1, 7'h06, 1);
    $display("test partial protection done");
    pg(4'h1, 11'h0, 14'h0, 0);
    ref_m.delete();
    pg(4'h2, 11'h0, 14'h0001, 0);
    pg(4'h0, 11'h0A, 14'h0, 1);
    pg(4'h4, 11'h100, 14'h0, 1);
    op(1, 11'h700, 8'h55, 1, 7'h06, 1);
    op(0, 11'h0B, 8'h55, 1, 7'h06, 1);
    $display("test full protection done");
    end_sim();
  end
endmodule // tb
